// ---- verilog/pcn_pkg.sv ----
// Notes on behaviour
// - Any single pin or any mix of pins across all ports can be made a change source.
// - Every pin has its own rising-edge detector and its own falling-edge detector.
// - A rising edge counts only while the pin's rising-edge enable bit is one.
// - A falling edge counts only while the pin's falling-edge enable bit is one.
// - With both enable bits set a pin reacts to edges of either polarity.
// - An enabled edge sets the pin's status flag, which stays set until software clears it.
// - Detection and flags keep working with the change enable clear; only the request and the wake wait.
// - The summary flag is the OR of every per-pin status flag on every port.
// - Writing zero to a status flag bit clears that flag.
// - An edge arriving during a write to its flag register leaves the flag set.
// - With the change enable set an enabled pin edge wakes the device from sleep.
// - An edge seen in sleep is in the flag registers before the first instruction after wake.
// - Port B registers and port C bits 6 and 7 exist only on the larger-pin variant.
package pcn_pkg;

    // ==========================================
    // sizes
    localparam int PORTS  = 3;
    localparam int PW     = 8;
    localparam int ADDR_W = 16;
    localparam int IDX_W  = 14;

    // ==========================================
    // register indices, byte address is four times these
    localparam logic [IDX_W-1:0] IDX_A_RISE = 14'h1f3d;
    localparam logic [IDX_W-1:0] IDX_A_FALL = 14'h1f3e;
    localparam logic [IDX_W-1:0] IDX_A_FLAG = 14'h1f3f;
    localparam logic [IDX_W-1:0] IDX_B_RISE = 14'h1f48;
    localparam logic [IDX_W-1:0] IDX_B_FALL = 14'h1f49;
    localparam logic [IDX_W-1:0] IDX_B_FLAG = 14'h1f4a;
    localparam logic [IDX_W-1:0] IDX_C_RISE = 14'h1f53;
    localparam logic [IDX_W-1:0] IDX_C_FALL = 14'h1f54;
    localparam logic [IDX_W-1:0] IDX_C_FLAG = 14'h1f55;
    localparam logic [IDX_W-1:0] IDX_CTRL   = 14'h1f60;
    localparam logic [IDX_W-1:0] IDX_STAT   = 14'h1f61;
    localparam logic [IDX_W-1:0] IDX_MASK   = 14'h1f62;

    // ==========================================
    // implemented bits per port
    localparam logic [PW-1:0] MASK_A       = 8'h3f;
    localparam logic [PW-1:0] MASK_B_LARGE = 8'hf0;
    localparam logic [PW-1:0] MASK_C_LARGE = 8'hff;
    localparam logic [PW-1:0] MASK_C_SMALL = 8'h3f;
    localparam logic [PW-1:0] MASK_NONE    = 8'h00;

    // ==========================================
    // control register fields and reset values
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_SUM_BIT = 1;
    localparam logic [PW-1:0]    REG_RST  = 8'h00;
    localparam logic [PORTS-1:0] STAT_RST = 3'h0;
    localparam logic [2:0]       PRIME_FULL = 3'h7;
    localparam logic [1:0]       ADDR_ALIGN = 2'h0;

    // ==========================================
    // types
    typedef logic [PORTS-1:0][PW-1:0] pcn_bank_t;

    typedef struct packed {
        logic [PW-1:0] porta;
        logic [PW-1:0] portb;
        logic [PW-1:0] portc;
    } pcn_pins_t;

    typedef enum logic [0:0] {
        PCN_IDLE = 1'b0,
        PCN_ANS  = 1'b1
    } pcn_apb_st_t;

    typedef struct packed {
        pcn_bank_t        sync1;
        pcn_bank_t        sync2;
        pcn_bank_t        prev;
        logic [2:0]       prime;
        pcn_bank_t        rise_en;
        pcn_bank_t        fall_en;
        pcn_bank_t        flags;
        logic             chg_en;
        logic [PORTS-1:0] stat;
        logic [PORTS-1:0] mask;
        logic             irq;
        logic             chg_req;
        logic             summary;
        logic             wake;
        pcn_apb_st_t      bus_st;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } pcn_state_t;

endpackage

// ---- verilog/pcn_top.sv ----
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

module pcn_top
    import pcn_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // pins and system
    input  wire pcn_pins_t         pins,
    input  wire logic              sleep_mode,
    output logic                   change_irq_req,
    output logic                   change_irq_summary_flag,
    output logic                   wake_req,
    output logic                   irq
);

    // ==========================================
    // constant tables
    localparam logic [PORTS-1:0][IDX_W-1:0] RISE_IDX = {IDX_C_RISE, IDX_B_RISE, IDX_A_RISE};
    localparam logic [PORTS-1:0][IDX_W-1:0] FALL_IDX = {IDX_C_FALL, IDX_B_FALL, IDX_A_FALL};
    localparam logic [PORTS-1:0][IDX_W-1:0] FLAG_IDX = {IDX_C_FLAG, IDX_B_FLAG, IDX_A_FLAG};

    // absent bits are held at zero, so they read zero and never detect
    localparam logic [PW-1:0] MASK_B = LARGE_VARIANT ? MASK_B_LARGE : MASK_NONE;
    localparam logic [PW-1:0] MASK_C = LARGE_VARIANT ? MASK_C_LARGE : MASK_C_SMALL;
    localparam pcn_bank_t PMASK = {MASK_C, MASK_B, MASK_A};

    pcn_state_t st_ff;
    pcn_state_t nxt_st;

    // ==========================================
    // bus decode
    logic [IDX_W-1:0] idx;
    logic             aligned;
    logic             wr_go;

    assign idx     = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == ADDR_ALIGN);
    // write lands only at the access edge with pready seen high
    assign wr_go   = psel & penable & pwrite & st_ff.pready & aligned;

    // ==========================================
    // per-port edge detection and register next values
    pcn_bank_t        pin_bank;
    pcn_bank_t        det;
    pcn_bank_t        nxt_rise;
    pcn_bank_t        nxt_fall;
    pcn_bank_t        nxt_flag;
    logic [PORTS-1:0] port_evt;
    logic             armed;

    assign pin_bank = {pins.portc, pins.portb, pins.porta};
    // previous sample is junk until the chain has filled
    assign armed = (st_ff.prime == PRIME_FULL);

    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            logic [PW-1:0] rise_hit;
            logic [PW-1:0] fall_hit;
            logic [PW-1:0] flag_base;

            // separate detectors per pin, compared against last sample
            assign rise_hit = st_ff.sync2[p] & ~st_ff.prev[p];
            assign fall_hit = ~st_ff.sync2[p] & st_ff.prev[p];

            // each polarity gated by its own enable, both may be on
            assign det[p] = {PW{armed}} & PMASK[p] &
                ((rise_hit & st_ff.rise_en[p]) |
                 (fall_hit & st_ff.fall_en[p]));

            assign nxt_rise[p] = (wr_go && idx == RISE_IDX[p]) ?
                (pwdata[PW-1:0] & PMASK[p]) : st_ff.rise_en[p];
            assign nxt_fall[p] = (wr_go && idx == FALL_IDX[p]) ?
                (pwdata[PW-1:0] & PMASK[p]) : st_ff.fall_en[p];

            // a written zero clears, a fresh edge overrides the write
            assign flag_base = (wr_go && idx == FLAG_IDX[p]) ?
                (pwdata[PW-1:0] & PMASK[p]) : st_ff.flags[p];
            assign nxt_flag[p] = flag_base | det[p];

            assign port_evt[p] = |det[p];
        end
    endgenerate

    // ==========================================
    // read data mux
    logic [31:0] rd_val;
    logic        rd_hit;

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
        for (int i = 0; i < PORTS; i++) begin
            if (idx == RISE_IDX[i]) begin
                rd_val = {24'h00_0000, st_ff.rise_en[i]};
                rd_hit = 1'b1;
            end
            if (idx == FALL_IDX[i]) begin
                rd_val = {24'h00_0000, st_ff.fall_en[i]};
                rd_hit = 1'b1;
            end
            if (idx == FLAG_IDX[i]) begin
                rd_val = {24'h00_0000, st_ff.flags[i]};
                rd_hit = 1'b1;
            end
        end
        if (idx == IDX_CTRL) begin
            rd_val[CTRL_EN_BIT]  = st_ff.chg_en;
            rd_val[CTRL_SUM_BIT] = st_ff.summary;
            rd_hit = 1'b1;
        end
        if (idx == IDX_STAT) begin
            rd_val[PORTS-1:0] = st_ff.stat;
            rd_hit = 1'b1;
        end
        if (idx == IDX_MASK) begin
            rd_val[PORTS-1:0] = st_ff.mask;
            rd_hit = 1'b1;
        end
        if (!aligned) begin
            rd_hit = 1'b0;
        end
    end

    // ==========================================
    // next state
    always_comb begin
        nxt_st = st_ff;

        // two flops then a history flop per pin
        nxt_st.sync1 = pin_bank;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev  = st_ff.sync2;
        nxt_st.prime = {st_ff.prime[1:0], 1'b1};

        nxt_st.rise_en = nxt_rise;
        nxt_st.fall_en = nxt_fall;
        nxt_st.flags   = nxt_flag;

        if (wr_go && idx == IDX_CTRL) begin
            nxt_st.chg_en = pwdata[CTRL_EN_BIT];
        end
        if (wr_go && idx == IDX_MASK) begin
            nxt_st.mask = pwdata[PORTS-1:0];
        end
        // write one clears, a same-cycle event still wins
        if (wr_go && idx == IDX_STAT) begin
            nxt_st.stat = st_ff.stat & ~pwdata[PORTS-1:0];
        end
        nxt_st.stat = nxt_st.stat | port_evt;

        // summary and request follow the flags in the same edge
        nxt_st.summary = |nxt_flag;
        nxt_st.chg_req = nxt_st.summary & nxt_st.chg_en;
        nxt_st.irq     = |(nxt_st.stat & nxt_st.mask);
        // flags and wake rise at one edge, so flags lead the first fetch
        nxt_st.wake = sleep_mode & st_ff.chg_en & (|port_evt);

        // apb: zero wait states, answer in first access cycle
        nxt_st.pready  = 1'b0;
        nxt_st.pslverr = 1'b0;
        case (st_ff.bus_st)
            PCN_IDLE: begin
                if (psel && !penable) begin
                    nxt_st.bus_st  = PCN_ANS;
                    nxt_st.pready  = 1'b1;
                    nxt_st.pslverr = ~rd_hit;
                    // refused reads return zero, even when the index hits
                    nxt_st.prdata  = (pwrite || !rd_hit) ? 32'h0000_0000 : rd_val;
                end
            end
            PCN_ANS: begin
                nxt_st.bus_st = PCN_IDLE;
            end
            default: begin
                nxt_st.bus_st = PCN_IDLE;
            end
        endcase
    end

    // ==========================================
    // state register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_ff         <= '0;
            st_ff.rise_en <= {PORTS{REG_RST}};
            st_ff.fall_en <= {PORTS{REG_RST}};
            st_ff.flags   <= {PORTS{REG_RST}};
            st_ff.stat    <= STAT_RST;
            st_ff.mask    <= STAT_RST;
            st_ff.bus_st  <= PCN_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================
    // outputs, all straight from the state flops
    assign prdata                  = st_ff.prdata;
    assign pready                  = st_ff.pready;
    assign pslverr                 = st_ff.pslverr;
    assign change_irq_req          = st_ff.chg_req;
    assign change_irq_summary_flag = st_ff.summary;
    assign wake_req                = st_ff.wake;
    assign irq                     = st_ff.irq;

endmodule

// ---- dv/pcn_pin_drv.sv ----
`timescale 1ns/1ps
// ==========================================
// far-side pin source
module pcn_pin_drv
    import pcn_pkg::*;
(
    input  wire logic sys_clk,
    output pcn_pins_t pins
);
    initial pins = '0;
    // new level on a clock edge, held until the next call: a level
    // shorter than a cycle could slip past the synchroniser
    task automatic drive(input pcn_pins_t v);
        @(posedge sys_clk);
        pins <= v;
    endtask
endmodule

// ---- dv/pcn_chk_assertions.sv ----
`timescale 1ns/1ps
// ==========================================
// port checker: handshake, flag and request coupling
module pcn_chk
    import pcn_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleep_mode,
    input wire logic        change_irq_req,
    input wire logic        change_irq_summary_flag,
    input wire logic        wake_req,
    input wire logic        irq
);
    logic bus_wr;
    // sticky outputs may only drop on a completed write
    assign bus_wr = psel && penable && pwrite;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // setup, then the single zero-wait access cycle
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && pready; endsequence
    property p_ready; s_setup |=> s_access; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error without ready or with data");
    property p_req; change_irq_req |-> change_irq_summary_flag; endproperty
    a_req: assert property (p_req) else $error("request without summary");
    property p_wake; wake_req |-> change_irq_summary_flag && $past(sleep_mode); endproperty
    a_wake: assert property (p_wake) else $error("wake without flag or sleep");
    property p_sum_hold; $fell(change_irq_summary_flag) |-> $past(bus_wr); endproperty
    a_sum_hold: assert property (p_sum_hold) else $error("summary dropped");
    property p_req_hold; $fell(change_irq_req) |-> $past(bus_wr); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_irq_hold; $fell(irq) |-> $past(bus_wr); endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
endmodule

bind pcn_top pcn_chk pcn_chk_inst (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode), .change_irq_req(change_irq_req),
    .change_irq_summary_flag(change_irq_summary_flag), .wake_req(wake_req), .irq(irq));

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
// ==========================================
// bench: apb master, pin stimulus, integer model
module tb_top
    import pcn_pkg::*;
;
    logic              sys_clk, resetn, psel, penable, pwrite, sleep_mode;
    logic              pready, pslverr, change_irq_req, change_irq_summary_flag, wake_req, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, r, prdata_s, r_s;
    pcn_pins_t         pins, cur;
    int                failures, check_count, cyc, wake_cnt, seed, en, st, im;
    int                m[3][3];
    int                mk[3] = '{MASK_A, MASK_B_LARGE, MASK_C_LARGE};
    int                mks[3] = '{MASK_A, MASK_NONE, MASK_C_SMALL};

    pcn_top #(.LARGE_VARIANT(1'b1)) pcn_top_inst (.sys_clk(sys_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .sleep_mode(sleep_mode), .change_irq_req(change_irq_req),
        .change_irq_summary_flag(change_irq_summary_flag), .wake_req(wake_req), .irq(irq));
    // small variant on the same bus: its absent port bits must read zero
    pcn_top #(.LARGE_VARIANT(1'b0)) pcn_top_small_inst (.sys_clk(sys_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata_s), .pready(), .pslverr(), .pins(pins), .sleep_mode(sleep_mode),
        .change_irq_req(), .change_irq_summary_flag(), .wake_req(), .irq());
    pcn_pin_drv pcn_pin_drv_inst (.sys_clk(sys_clk), .pins(pins));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // wake pulse counter and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (wake_req === 1'b1) wake_cnt++;
        if (cyc > 20000) begin
            failures++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    // registers sit at one index per port step of 11: rise, fall, flags
    function automatic logic [IDX_W-1:0] ix(int p, int k);
        return IDX_A_RISE + IDX_W'(11 * p + k);
    endfunction
    task automatic apb(input bit w, input logic [IDX_W-1:0] a, input int d, input bit err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, ADDR_ALIGN};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no fixed wait assumed; only the cycle guard ends a hang
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata;
        r_s = prdata_s;
        chk("pslverr", err, pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(int p, int k, int d);
        apb(1, ix(p, k), d, 0);
        m[p][k] = d & mk[p];
    endtask
    task automatic rd(int p, int k);
        apb(0, ix(p, k), 0, 0);
        chk("reg", m[p][k], r);
        chk("reg_small", m[p][k] & mks[p], r_s);
    endtask
    // outputs settle a couple of edges after the last write
    task automatic outs();
        int s;
        repeat (2) @(posedge sys_clk);
        #1;
        s = (m[0][2] | m[1][2] | m[2][2]) != 0;
        chk("summary", s, change_irq_summary_flag);
        chk("request", s & en, change_irq_req);
        chk("irq", (st & im) != 0, irq);
    endtask
    // one pin change, optionally racing a flag clear; model edge wins
    task automatic step(pcn_pins_t v, bit clr);
        int d, any, w0;
        w0 = wake_cnt;
        any = 0;
        pcn_pin_drv_inst.drive(v);
        if (clr) wr(0, 2, 0);
        repeat (5) @(posedge sys_clk);
        for (int p = 0; p < 3; p++) begin
            d = (v[8*(2-p)+:8] & ~cur[8*(2-p)+:8] & m[p][0]
                | ~v[8*(2-p)+:8] & cur[8*(2-p)+:8] & m[p][1]) & mk[p];
            m[p][2] |= d;
            if (d != 0) st |= 1 << p;
            any |= d;
        end
        cur = v;
        chk("wake", any != 0 && sleep_mode && en, wake_cnt - w0);
        outs();
        for (int p = 0; p < 3; p++) rd(p, 2);
    endtask

    initial begin
        {psel, penable, pwrite, sleep_mode, resetn} = '0;
        paddr = '0;
        pwdata = '0;
        cur = '0;
        seed = 32'hf814;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            apb(0, i < 9 ? ix(i / 3, i % 3) : IDX_CTRL + IDX_W'(i - 9), 0, 0);
            chk("reset", 0, r);
            chk("reset_small", 0, r_s);
        end
        apb(0, IDX_CTRL + 14'h10, 0, 1);
        chk("unmapped", 0, r);
        for (int i = 0; i < 6; i++) begin
            wr(i / 2, i % 2, $random(seed));
            rd(i / 2, i % 2);
        end
        repeat (6) step(24'($random(seed)), 0);
        en = 1;
        im = 7;
        apb(1, IDX_CTRL, en, 0);
        apb(1, IDX_MASK, im, 0);
        outs();
        apb(0, IDX_CTRL, 0, 0);
        chk("ctrl", ((m[0][2] | m[1][2] | m[2][2]) != 0) * 2 + en, r);
        for (int p = 0; p < 3; p++) wr(p, 2, m[p][2] & 'h0f);
        apb(1, IDX_STAT, 7, 0);
        st = 0;
        outs();
        @(posedge sys_clk);
        sleep_mode <= 1'b1;
        for (int i = 0; i < 6; i++) wr(i / 2, i % 2, 'hff);
        repeat (4) step(24'($random(seed)), 0);
        step(~cur, 1);
        for (int p = 0; p < 3; p++) wr(p, 2, 0);
        outs();
        end_sim();
    end
endmodule
